// >>> src/etw_pkg.sv
// Shared constants and types of the extended timer, watchdog and feature control block.
// Assumes a 32-bit AXI4-Lite register bus and a 12-phase machine cycle.
package etw_pkg;
  // ==========================================================
  // Machine cycle timing
  localparam int unsigned MC_PHASES  = 12;
  localparam int unsigned PH_S1P1    = 0;
  localparam int unsigned PH_S3P1    = 4;
  localparam int unsigned PH_S5P1    = 8;
  localparam int unsigned PH_S5P2    = 9;
  localparam int unsigned WD_RST_MC  = 5;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_FEATURE = 8'h00;
  localparam logic [7:0] OFF_TIMER0  = 8'h04;
  localparam logic [7:0] OFF_TIMER1  = 8'h08;
  localparam logic [7:0] OFF_TCTRL   = 8'h0c;
  localparam logic [7:0] OFF_POWER   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  // ==========================================================
  // feature_control fields
  localparam int unsigned FC_PD_FLOAT_ALL = 0;
  localparam int unsigned FC_PORT1_FLOAT  = 1;
  localparam int unsigned FC_PULLUP_SEL   = 4;
  localparam int unsigned FC_SERIAL_ERR   = 5;
  localparam int unsigned FC_CHAIN_EN     = 6;
  localparam int unsigned FC_WDOG_EN      = 7;
  localparam logic [7:0]  FC_RESET        = 8'h00;
  // Timer control fields
  localparam int unsigned TC_COUNT_SRC = 0;
  localparam int unsigned TC_LOW_RUN   = 1;
  localparam int unsigned TC_HIGH_RUN  = 2;
  localparam int unsigned TC_LOW_OVF   = 3;
  localparam int unsigned TC_HIGH_OVF  = 4;
  // Power control fields
  localparam int unsigned PC_IDLE      = 0;
  localparam int unsigned PC_PDOWN     = 1;
  localparam int unsigned PC_HW_PDOWN  = 2;
  localparam int unsigned PC_RECOVER   = 3;
  // Status fields
  localparam int unsigned ST_RX_DONE   = 0;
  localparam int unsigned ST_PDOWN     = 1;
  localparam int unsigned ST_WD_RESET  = 2;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_DOWN} etw_pwr_type;
  typedef struct packed {
    logic s1p1;
    logic s3p1;
    logic s5p1;
    logic s5p2;
  } etw_phase_type;
  typedef struct packed {
    logic [2:0] strongPullup;
    logic [2:0] weakPullup;
    logic [2:0] floating;
  } etw_port_ctl_type;
endpackage

// >>> src/etw_sync.sv
// Three-stage pin synchroniser; output follows once the last two stages agree.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module etw_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Pin and synchronised level
  input  wire logic pinIn,
  output logic      level
);
  logic q1_r;
  logic q2_r;
  logic q3_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
      q3_r <= 1'b0;
    end else begin
      q1_r <= pinIn;
      q2_r <= q1_r;
      q3_r <= q2_r;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
    end else if (q2_r == q3_r) begin
      level <= q3_r;
    end
  end
endmodule

// >>> src/etw_phase.sv
// Machine cycle phase divider producing one-cycle state strobes.
// Assumes run is low while the oscillator is meant to be stopped.
`timescale 1ns/1ps
module etw_phase #(
  parameter int unsigned PHASES = etw_pkg::MC_PHASES
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // Control and strobes
  input  wire logic          run,
  output etw_pkg::etw_phase_type strobe
);
  if (PHASES <= etw_pkg::PH_S5P2 || PHASES > 16) begin
    $error("PHASES out of range");
  end

  logic [3:0] phase_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 4'h0;
    end else if (run) begin
      phase_r <= (phase_r == 4'(PHASES - 1)) ? 4'h0 : phase_r + 4'h1;
    end
  end

  always_comb begin
    strobe.s1p1 = run & (phase_r == 4'(etw_pkg::PH_S1P1));
    strobe.s3p1 = run & (phase_r == 4'(etw_pkg::PH_S3P1));
    strobe.s5p1 = run & (phase_r == 4'(etw_pkg::PH_S5P1));
    strobe.s5p2 = run & (phase_r == 4'(etw_pkg::PH_S5P2));
  end
endmodule

// >>> src/etw_top.sv
// Extended timer, watchdog, port impedance, power mode and serial error logic.
// Assumes an AXI4-Lite master, a same-clock serial receiver and same-clock interrupt sources.
//
// Notes on behaviour
// - Float bit and pull-up select zero: strong low-impedance pull-up; reset state.
// - Float bit zero, select one: only the weak pull-up is on.
// - Float bit one: all port transistors off; float bits sit at 1..3.
// - Float-all set floats ports in power-down; restored on wake request.
// - Chain enable joins timers; count source picks timer or event counter.
// - Timer 0 low half, timer 1 high half; chain enable starts and stops.
// - Chain off returns timers to own settings; software clears run bits to stop.
// - Chain increments at S3P1; low carry sets no flag; full overflow flags at S5P1.
// - Counter samples pin at S5P2; counts after a one then a later zero.
// - Watchdog enable: any overflow setting the high overflow flag arms reset.
// - Watchdog counts machine cycles, or external edges when chained with count source set.
// - Reset starts next machine cycle, lasts five machine cycles, keeps RAM.
// - Watchdog reset zeroes these registers; other core registers handled outside.
// - In power-down timers count pin edges; overflow interrupts or resets.
// - Recover bit: idle wake resumes without running the service routine.
// - Enter power-down on power-down bit or hardware enable with pin falling edge.
// - Leave power-down on interrupt plus pin rising edge; else only reset.
// - Serial error flag set at stop-bit midpoint; only software or a watchdog reset clears it.
// - Frame error when the stop bit is missing.
// - Overrun when a character arrives while receive-complete is still set.
// - Receive-complete is set during the stop bit.
`timescale 1ns/1ps
module etw_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // AXI4-Lite write
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // Timer pins
  input  wire logic                 lowTimerInputPin,
  input  wire logic                 highTimerInputPin,
  // Serial receiver events
  input  wire logic                 rxStopMid,
  input  wire logic                 rxStopLevel,
  // Interrupt request and power outputs
  input  wire logic                 wakeIrq,
  output logic                      timerIrq,
  output logic                      powerDownActive,
  output logic                      idleActive,
  output logic                      isrSkip,
  output logic                      isrService,
  // Watchdog, ports and serial status
  output logic                      watchdogReset,
  output etw_pkg::etw_port_ctl_type portCtl,
  output logic                      receiveComplete,
  output logic                      serialError
);
  if (ADDR_W < 5) begin
    $error("ADDR_W too small");
  end

  // ==========================================================
  // Address decode
  function automatic logic [3:0] decodeAddr(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    case (a)
      etw_pkg::OFF_FEATURE: decodeAddr = 4'h8;
      etw_pkg::OFF_TIMER0:  decodeAddr = 4'h9;
      etw_pkg::OFF_TIMER1:  decodeAddr = 4'ha;
      etw_pkg::OFF_TCTRL:   decodeAddr = 4'hb;
      etw_pkg::OFF_POWER:   decodeAddr = 4'hc;
      etw_pkg::OFF_STATUS:  decodeAddr = 4'hd;
      default:              decodeAddr = 4'h0;
    endcase
  endfunction

  // ==========================================================
  // Declarations
  logic          awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0]   wData_r, rdata_r;
  logic [3:0]    wStrb_r;
  logic [1:0]    bresp_r, rresp_r;
  logic          wrFire;
  logic [3:0]    wrDec, rdDec;
  logic [7:0]    fc_r;
  logic [15:0]   t0_r, t1_r;
  logic [4:0]    tc_r;
  logic [1:0]    pc_r;
  logic          ri_r;
  logic          t0Lvl, t1Lvl, t0Prev_r, t1Prev_r;
  logic          t0Fall, t1Fall, t1Rise;
  logic          seenHigh_r, cntPend_r, tf1Pend_r;
  logic          wdPend_r, wdRst_r;
  logic [2:0]    wdCnt_r;
  etw_pkg::etw_pwr_type  pwr_r;
  etw_pkg::etw_phase_type ph;
  logic          pd, wdClear, irqReq, pdFloat;
  logic          evtLow, evtHigh, tf0Set, tf1Arm, tf1Set, serrSet;
  logic [32:0]   sum32;
  logic [16:0]   sum0, sum1;
  logic          wrFc, wrT0, wrT1, wrTc, wrPc, wrSt;

  // ==========================================================
  // Pin synchronisers and phase divider
  etw_sync u_syncLow (
    .clock  (clock),
    .arst_n (arst_n),
    .pinIn  (lowTimerInputPin),
    .level  (t0Lvl)
  );
  etw_sync u_syncHigh (
    .clock  (clock),
    .arst_n (arst_n),
    .pinIn  (highTimerInputPin),
    .level  (t1Lvl)
  );
  etw_phase u_phase (
    .clock  (clock),
    .arst_n (arst_n),
    .run    (~pd | wdPend_r | wdRst_r),
    .strobe (ph)
  );

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      t0Prev_r <= 1'b0;
      t1Prev_r <= 1'b0;
    end else begin
      t0Prev_r <= t0Lvl;
      t1Prev_r <= t1Lvl;
    end
  end
  assign t0Fall = t0Prev_r & ~t0Lvl;
  assign t1Fall = t1Prev_r & ~t1Lvl;
  assign t1Rise = ~t1Prev_r & t1Lvl;

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = ~awHeld_r & ~bvalid_r;
  assign s_axi_wready  = ~wHeld_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wrFire        = awHeld_r & wHeld_r & ~bvalid_r;
  assign wrDec         = decodeAddr(awAddr_r);
  assign rdDec         = decodeAddr(s_axi_araddr);
  assign wrFc = wrFire & (wrDec == 4'h8);
  assign wrT0 = wrFire & (wrDec == 4'h9);
  assign wrT1 = wrFire & (wrDec == 4'ha);
  assign wrTc = wrFire & (wrDec == 4'hb) & wStrb_r[0];
  assign wrPc = wrFire & (wrDec == 4'hc) & wStrb_r[0];
  assign wrSt = wrFire & (wrDec == 4'hd) & wStrb_r[0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= etw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wrDec[3] ? etw_pkg::RESP_OKAY : etw_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= etw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rdDec[3] ? etw_pkg::RESP_OKAY : etw_pkg::RESP_SLVERR;
      case (rdDec)
        4'h8:    rdata_r <= {24'h0, fc_r};
        4'h9:    rdata_r <= {16'h0, t0_r};
        4'ha:    rdata_r <= {16'h0, t1_r};
        4'hb:    rdata_r <= {27'h0, tc_r};
        4'hc:    rdata_r <= {28'h0, pc_r, pwr_r == etw_pkg::PWR_DOWN,
                             pwr_r == etw_pkg::PWR_IDLE};
        4'hd:    rdata_r <= {29'h0, wdRst_r, pd, ri_r};
        default: rdata_r <= 32'h0;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Feature control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fc_r <= etw_pkg::FC_RESET;
    end else if (wdClear) begin
      fc_r <= etw_pkg::FC_RESET;
    end else begin
      if (wrFc && wStrb_r[0]) begin
        fc_r <= wData_r[7:0];
        fc_r[etw_pkg::FC_SERIAL_ERR] <= fc_r[etw_pkg::FC_SERIAL_ERR] &
                                        wData_r[etw_pkg::FC_SERIAL_ERR];
      end
      if (serrSet) begin
        fc_r[etw_pkg::FC_SERIAL_ERR] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Port impedance
  assign pdFloat = pd & fc_r[etw_pkg::FC_PD_FLOAT_ALL] & ~irqReq;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portCtl <= '{strongPullup: 3'h7, weakPullup: 3'h0, floating: 3'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        portCtl.floating[i] <= fc_r[etw_pkg::FC_PORT1_FLOAT + i] | pdFloat;
        portCtl.weakPullup[i] <= ~fc_r[etw_pkg::FC_PORT1_FLOAT + i] & ~pdFloat &
                                 fc_r[etw_pkg::FC_PULLUP_SEL];
        portCtl.strongPullup[i] <= ~fc_r[etw_pkg::FC_PORT1_FLOAT + i] & ~pdFloat &
                                   ~fc_r[etw_pkg::FC_PULLUP_SEL];
      end
    end
  end

  // ==========================================================
  // Count events
  assign pd = (pwr_r == etw_pkg::PWR_DOWN);
  assign evtLow = pd ? t0Fall
                : (tc_r[etw_pkg::TC_COUNT_SRC] ? (ph.s3p1 & cntPend_r) : ph.s3p1);
  assign evtHigh = pd ? t1Fall : ph.s3p1;
  assign sum32 = {1'b0, t1_r, t0_r} + 33'h1;
  assign sum0  = {1'b0, t0_r} + 17'h1;
  assign sum1  = {1'b0, t1_r} + 17'h1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seenHigh_r <= 1'b0;
      cntPend_r  <= 1'b0;
    end else if (wdClear) begin
      seenHigh_r <= 1'b0;
      cntPend_r  <= 1'b0;
    end else begin
      if (ph.s3p1) begin
        cntPend_r <= 1'b0;
      end
      if (ph.s5p2) begin
        if (t0Lvl) begin
          seenHigh_r <= 1'b1;
        end else if (seenHigh_r) begin
          seenHigh_r <= 1'b0;
          cntPend_r  <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Timers
  always_comb begin
    tf0Set = 1'b0;
    tf1Arm = 1'b0;
    if (fc_r[etw_pkg::FC_CHAIN_EN]) begin
      tf1Arm = evtLow & sum32[32];
    end else begin
      tf0Set = tc_r[etw_pkg::TC_LOW_RUN] & evtLow & sum0[16];
      tf1Arm = tc_r[etw_pkg::TC_HIGH_RUN] & evtHigh & sum1[16];
    end
  end
  assign tf1Set = tf1Pend_r & (ph.s5p1 | pd);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      t0_r <= 16'h0;
      t1_r <= 16'h0;
    end else if (wdClear) begin
      t0_r <= 16'h0;
      t1_r <= 16'h0;
    end else begin
      if (fc_r[etw_pkg::FC_CHAIN_EN]) begin
        if (evtLow) begin
          {t1_r, t0_r} <= sum32[31:0];
        end
      end else begin
        if (tc_r[etw_pkg::TC_LOW_RUN] && evtLow) begin
          t0_r <= sum0[15:0];
        end
        if (tc_r[etw_pkg::TC_HIGH_RUN] && evtHigh) begin
          t1_r <= sum1[15:0];
        end
      end
      if (wrT0 && wStrb_r[0]) t0_r[7:0]  <= wData_r[7:0];
      if (wrT0 && wStrb_r[1]) t0_r[15:8] <= wData_r[15:8];
      if (wrT1 && wStrb_r[0]) t1_r[7:0]  <= wData_r[7:0];
      if (wrT1 && wStrb_r[1]) t1_r[15:8] <= wData_r[15:8];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tc_r      <= 5'h0;
      tf1Pend_r <= 1'b0;
    end else if (wdClear) begin
      tc_r      <= 5'h0;
      tf1Pend_r <= 1'b0;
    end else begin
      if (tf1Arm) begin
        tf1Pend_r <= 1'b1;
      end else if (tf1Set) begin
        tf1Pend_r <= 1'b0;
      end
      if (wrTc) begin
        tc_r[2:0] <= wData_r[2:0];
        tc_r[etw_pkg::TC_LOW_OVF]  <= tc_r[etw_pkg::TC_LOW_OVF] &
                                      ~wData_r[etw_pkg::TC_LOW_OVF];
        tc_r[etw_pkg::TC_HIGH_OVF] <= tc_r[etw_pkg::TC_HIGH_OVF] &
                                      ~wData_r[etw_pkg::TC_HIGH_OVF];
      end
      if (tf0Set) tc_r[etw_pkg::TC_LOW_OVF] <= 1'b1;
      if (tf1Set) tc_r[etw_pkg::TC_HIGH_OVF] <= 1'b1;
    end
  end
  assign timerIrq = tc_r[etw_pkg::TC_LOW_OVF] | tc_r[etw_pkg::TC_HIGH_OVF];

  // ==========================================================
  // Watchdog reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdPend_r <= 1'b0;
      wdRst_r  <= 1'b0;
      wdCnt_r  <= 3'h0;
    end else if (wdPend_r && ph.s1p1) begin
      wdPend_r <= 1'b0;
      wdRst_r  <= 1'b1;
      wdCnt_r  <= 3'(etw_pkg::WD_RST_MC);
    end else if (wdRst_r) begin
      if (ph.s1p1) begin
        if (wdCnt_r == 3'h1) wdRst_r <= 1'b0;
        wdCnt_r <= wdCnt_r - 3'h1;
      end
    end else if (fc_r[etw_pkg::FC_WDOG_EN] && tf1Set) begin
      wdPend_r <= 1'b1;
    end
  end
  assign wdClear       = wdRst_r;
  assign watchdogReset = wdRst_r;

  // ==========================================================
  // Power modes
  assign irqReq = wakeIrq | timerIrq;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_r      <= etw_pkg::PWR_RUN;
      pc_r       <= 2'h0;
      isrSkip    <= 1'b0;
      isrService <= 1'b0;
    end else if (wdClear) begin
      pwr_r      <= etw_pkg::PWR_RUN;
      pc_r       <= 2'h0;
      isrSkip    <= 1'b0;
      isrService <= 1'b0;
    end else begin
      isrSkip    <= 1'b0;
      isrService <= 1'b0;
      if (wrPc) begin
        pc_r <= wData_r[etw_pkg::PC_RECOVER:etw_pkg::PC_HW_PDOWN];
      end
      case (pwr_r)
        etw_pkg::PWR_RUN: begin
          if ((wrPc && wData_r[etw_pkg::PC_PDOWN]) || (pc_r[0] && t1Fall)) begin
            pwr_r <= etw_pkg::PWR_DOWN;
          end else if (wrPc && wData_r[etw_pkg::PC_IDLE]) begin
            pwr_r <= etw_pkg::PWR_IDLE;
          end
        end
        etw_pkg::PWR_IDLE: begin
          if (irqReq) begin
            pwr_r      <= etw_pkg::PWR_RUN;
            isrSkip    <= pc_r[1];
            isrService <= ~pc_r[1];
          end
        end
        etw_pkg::PWR_DOWN: begin
          if (irqReq && t1Rise) begin
            pwr_r <= etw_pkg::PWR_RUN;
          end
        end
        default: pwr_r <= etw_pkg::PWR_RUN;
      endcase
    end
  end
  assign powerDownActive = pd;
  assign idleActive      = (pwr_r == etw_pkg::PWR_IDLE);

  // ==========================================================
  // Serial error detection
  assign serrSet = rxStopMid & (~rxStopLevel | ri_r);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ri_r <= 1'b0;
    end else if (wdClear) begin
      ri_r <= 1'b0;
    end else if (rxStopMid) begin
      ri_r <= 1'b1;
    end else if (wrSt && wData_r[etw_pkg::ST_RX_DONE]) begin
      ri_r <= 1'b0;
    end
  end
  assign receiveComplete = ri_r;
  assign serialError     = fc_r[etw_pkg::FC_SERIAL_ERR];
endmodule

// >>> verif/etw_checker.sv
// Port-level assertions for the extended timer block.
// Assumes it is bound to etw_top and sees only its ports.
`timescale 1ns/1ps
module etw_checker (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      arst_n,
  // Watched ports
  input wire logic                      rxStopMid,
  input wire logic                      rxStopLevel,
  input wire logic                      receiveComplete,
  input wire logic                      serialError,
  input wire logic                      watchdogReset,
  input wire logic                      timerIrq,
  input wire logic                      wakeIrq,
  input wire logic                      powerDownActive,
  input wire logic                      isrSkip,
  input wire logic                      isrService,
  input wire etw_pkg::etw_port_ctl_type portCtl
);
  // ==========================================================
  // Helpers
  logic [6:0] wdCnt_r;
  logic [2:0] sP, wP, fP;
  assign sP = portCtl.strongPullup;
  assign wP = portCtl.weakPullup;
  assign fP = portCtl.floating;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) wdCnt_r <= 7'h0;
    else if (watchdogReset) wdCnt_r <= wdCnt_r + 7'h1;
    else wdCnt_r <= 7'h0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Assertions
  property p_ports; ((sP | wP | fP) == 3'h7) && (((sP & wP) | (sP & fP) | (wP & fP)) == 3'h0);
  endproperty
  a_ports: assert property (p_ports) else $error("port modes overlap");
  property p_wdLen; $fell(watchdogReset) |-> wdCnt_r == 7'h3c; endproperty
  a_wdLen: assert property (p_wdLen) else $error("watchdog reset length wrong");
  property p_wdArm; $rose(watchdogReset) |-> $past(timerIrq); endproperty
  a_wdArm: assert property (p_wdArm) else $error("watchdog reset without overflow");
  property p_errSet; $rose(serialError) |-> $past(rxStopMid); endproperty
  a_errSet: assert property (p_errSet) else $error("serial error off stop midpoint");
  property p_frame; rxStopMid && !rxStopLevel |=> serialError; endproperty
  a_frame: assert property (p_frame) else $error("frame error missed");
  property p_ovr; rxStopMid && receiveComplete |=> serialError; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");
  property p_rxDone; rxStopMid |=> receiveComplete; endproperty
  a_rxDone: assert property (p_rxDone) else $error("receive complete not set");
  property p_exit; $fell(powerDownActive) |-> $past(wakeIrq) || $past(timerIrq) || watchdogReset;
  endproperty
  a_exit: assert property (p_exit) else $error("power-down left without request");
  property p_isr; !(isrSkip && isrService); endproperty
  a_isr: assert property (p_isr) else $error("skip and service together");
endmodule

// >>> verif/etw_top_tb.sv
// Self-checking bench of the extended timer block.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps
module etw_top_tb;
  // ==========================================================
  // Signals
  logic        clock = 1'b0, arst_n = 1'b0, awV = 1'b0, wV = 1'b0, arV = 1'b0;
  logic [7:0]  awA = 8'h00, arA = 8'h00;
  logic [31:0] wD = 32'h0, rD, rnd = 32'hff9d;
  logic        t0 = 1'b0, t1 = 1'b0, mid = 1'b0, lvl = 1'b1, irq = 1'b0;
  logic        awR, wR, bV, arR, rV, tIrq, pd, idl, skp, srv, wd, rc, se;
  logic [1:0]  bRs, rRs;
  etw_pkg::etw_port_ctl_type ports;
  logic [33:0] notes[$];
  int          bad_count = 0, n_compared = 0;
  etw_top i_etw_top (.clock(clock), .arst_n(arst_n), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_bresp(bRs),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA), .s_axi_rvalid(rV),
    .s_axi_rready(1'b1), .s_axi_rdata(rD), .s_axi_rresp(rRs), .lowTimerInputPin(t0),
    .highTimerInputPin(t1), .rxStopMid(mid), .rxStopLevel(lvl), .wakeIrq(irq),
    .timerIrq(tIrq), .powerDownActive(pd), .idleActive(idl), .isrSkip(skp),
    .isrService(srv), .watchdogReset(wd), .portCtl(ports), .receiveComplete(rc),
    .serialError(se));
  always #5 clock = ~clock;
  // ==========================================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [8:0] got, input logic [8:0] exp);
    cmp_bus({25'h0, got}, {25'h0, exp});
  endtask
  always @(posedge clock) begin
    if (bV) cmp_bus({bRs, 32'h0}, notes.pop_front());
    if (rV) cmp_bus({rRs, rD}, notes.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    notes.push_back({r, 32'h0});
    awV <= 1'b1;
    wV <= 1'b1;
    awA <= a;
    wD <= d;
    do @(negedge clock); while (!(awR && wR));
    @(posedge clock);
    awV <= 1'b0;
    wV <= 1'b0;
    do @(negedge clock); while (!bV);
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    notes.push_back({r, d});
    arV <= 1'b1;
    arA <= a;
    do @(negedge clock); while (!arR);
    @(posedge clock);
    arV <= 1'b0;
    do @(negedge clock); while (!rV);
    @(posedge clock);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic stop_bit(input logic l);
    mid <= 1'b1;
    lvl <= l;
    tick(1);
    mid <= 1'b0;
    tick(2);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  // ==========================================================
  // Scenarios
  initial begin
    tick(3);
    arst_n <= 1'b1;
    tick(1);
    cmp_pin(ports, 9'h1c0);
    rd(etw_pkg::OFF_FEATURE, 32'h0);
    rnd = xs(rnd);
    t0 <= rnd[0];
    wr(etw_pkg::OFF_TIMER0, rnd);
    rd(etw_pkg::OFF_TIMER0, {16'h0, rnd[15:0]});
    wr(etw_pkg::OFF_FEATURE, 32'h12);
    tick(3);
    cmp_pin(ports, 9'h031);
    wr(etw_pkg::OFF_FEATURE, 32'h0e);
    tick(3);
    cmp_pin(ports, 9'h007);
    wr(etw_pkg::OFF_FEATURE, 32'h01);
    wr(etw_pkg::OFF_POWER, 32'h02);
    tick(3);
    cmp_pin({pd, ports[7:0]}, 9'h107);
    irq <= 1'b1;
    t1 <= 1'b1;
    tick(8);
    cmp_pin({pd, ports[7:0]}, 9'h0c0);
    wr(etw_pkg::OFF_POWER, 32'h09);
    tick(1);
    cmp_pin({6'h0, idl, skp, srv}, 9'h002);
    irq <= 1'b0;
    wr(etw_pkg::OFF_POWER, 32'h04);
    t1 <= 1'b0;
    tick(8);
    t1 <= 1'b1;
    tick(8);
    cmp_pin({8'h0, pd}, 9'h001);
    irq <= 1'b1;
    tick(8);
    cmp_pin({8'h0, pd}, 9'h001);
    t1 <= 1'b0;
    tick(8);
    t1 <= 1'b1;
    tick(8);
    cmp_pin({8'h0, pd}, 9'h000);
    irq <= 1'b0;
    stop_bit(1'b0);
    rd(etw_pkg::OFF_FEATURE, 32'h21);
    wr(etw_pkg::OFF_FEATURE, 32'h01);
    rd(etw_pkg::OFF_STATUS, 32'h01);
    stop_bit(1'b1);
    cmp_pin({8'h0, se}, 9'h001);
    wr(etw_pkg::OFF_STATUS, 32'h01);
    wr(etw_pkg::OFF_TIMER0, 32'hffff);
    wr(etw_pkg::OFF_TIMER1, 32'hffff);
    wr(etw_pkg::OFF_FEATURE, 32'h40);
    tick(30);
    rd(etw_pkg::OFF_TCTRL, 32'h10);
    wr(etw_pkg::OFF_FEATURE, 32'h00);
    wr(etw_pkg::OFF_TCTRL, 32'h19);
    wr(etw_pkg::OFF_TIMER0, 32'hffff);
    wr(etw_pkg::OFF_TIMER1, 32'hffff);
    t0 <= 1'b0;
    tick(30);
    wr(etw_pkg::OFF_FEATURE, 32'h40);
    t0 <= 1'b1;
    tick(30);
    rd(etw_pkg::OFF_TCTRL, 32'h01);
    t0 <= 1'b0;
    tick(40);
    rd(etw_pkg::OFF_TCTRL, 32'h11);
    wr(etw_pkg::OFF_FEATURE, 32'hc0);
    wr(etw_pkg::OFF_TCTRL, 32'h18);
    wr(etw_pkg::OFF_TIMER1, 32'hffff);
    wr(etw_pkg::OFF_TIMER0, 32'hffff);
    wait (wd);
    wait (!wd);
    tick(1);
    rd(etw_pkg::OFF_FEATURE, 32'h0);
    rd(etw_pkg::OFF_TCTRL, 32'h0);
    wr(8'h20, 32'hff, etw_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0, etw_pkg::RESP_SLVERR);
    tick(4);
    finish_test();
  end
endmodule
bind etw_top etw_checker i_etw_checker (.clock(clock), .arst_n(arst_n), .rxStopMid(rxStopMid),
  .rxStopLevel(rxStopLevel), .receiveComplete(receiveComplete), .serialError(serialError),
  .watchdogReset(watchdogReset), .timerIrq(timerIrq), .wakeIrq(wakeIrq),
  .powerDownActive(powerDownActive), .isrSkip(isrSkip), .isrService(isrService),
  .portCtl(portCtl));
